// File: verilog/sbcso_setup_options.sv
// Setup options register with interrupt pin and debug-resistor logic
`timescale 1ns/100ps

// How it works
// - setup_options accepts writes only while the device is in init mode.
// - Bit 7 set makes low-power entry need the mode-write random code.
// - Bit 6 enables parity on writes; clear means the host sends zero.
// - Bit 5 clear gives a low interrupt pulse; set holds interrupt low.
// - Bit 4 picks pulse width: 0 about 100 us, 1 about 25 us.
// - Bit 3 with flash mode pulses interrupt at half the watchdog period.
// - Bits 2..0: 0xx off, 100/101/110 safe B3/B2/B1, 111 safe A.
// - Enabled check with mismatched detected resistor sets the debug flag.
// - With bit 2 set, the software variant overrides the pin-decoded one.
module sbcso_setup_options
  import sbcso_pkg::*;
#(
  parameter int unsigned INT_LONG_CYC  = SBCSO_INT_LONG_CYC,
  parameter int unsigned INT_SHORT_CYC = SBCSO_INT_SHORT_CYC
)
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           resetn,
  // Decoded serial frames
  input  wire logic           frame_valid,
  input  wire sbcso_frame_t   frame,
  // Device state
  input  wire sbcso_mode_t    dev_mode,
  input  wire logic           wd_half_elapsed,
  input  wire logic           int_event,
  input  wire logic           int_clear,
  input  wire logic           lp_entry_req,
  input  wire logic           lp_code_ok,
  // Debug pin resistor as decoded by hardware
  input  wire sbcso_variant_t pin_variant,
  input  wire logic           dbg_flag_clear,
  // Outputs
  output logic [7:0]          setup_options_q,
  output logic                wr_accept_q,
  output logic                wr_reject_q,
  output logic                lp_entry_grant_q,
  output logic                int_n_q,
  output logic                dbg_flag_q,
  output sbcso_variant_t      safe_variant_q
);

  // Maps a software setting to its variant
  function automatic sbcso_variant_t sel_variant(input logic [2:0] sel);
    case (sel[1:0])
      2'h0:    sel_variant = SBCSO_SAFE_B3;
      2'h1:    sel_variant = SBCSO_SAFE_B2;
      2'h2:    sel_variant = SBCSO_SAFE_B1;
      default: sel_variant = SBCSO_SAFE_A;
    endcase
  endfunction : sel_variant

  typedef enum logic [1:0] {
    SBCSO_INT_IDLE,
    SBCSO_INT_PULSE,
    SBCSO_INT_HOLD
  } sbcso_int_st_t;

  sbcso_setup_t       cfg;
  logic               par_calc;
  logic               is_write;
  logic               par_ok;
  logic               mismatch;
  logic               mismatch_q;
  logic               irq_event;
  logic [7:0]         setup_options_d;
  logic               wr_accept_d;
  logic               wr_reject_d;
  logic               lp_entry_grant_d;
  logic               dbg_flag_d;
  sbcso_variant_t     safe_variant_d;
  sbcso_int_st_t      int_st_q;
  sbcso_int_st_t      int_st_d;
  logic [SBCSO_CNT_W-1:0] int_cnt_q;
  logic [SBCSO_CNT_W-1:0] int_cnt_d;
  logic               int_n_d;

  assign cfg = sbcso_setup_t'(setup_options_q);

  // Register write path
  always_comb
  begin
    // Even parity over the fifteen other frame bits
    par_calc = ^{frame.cmd, frame.addr, frame.data};
    is_write = frame_valid && frame.cmd == SBCSO_CMD_WRITE &&
               frame.addr == SBCSO_SETUP_OFFSET;
    par_ok = !cfg.parity_en || frame.parity == par_calc;
    setup_options_d = setup_options_q;
    wr_accept_d = 1'b0;
    wr_reject_d = 1'b0;
    if (is_write)
    begin
      // Outside init mode the write is dropped but reported
      if (dev_mode == SBCSO_MODE_INIT && par_ok)
      begin
        setup_options_d = frame.data;
        wr_accept_d = 1'b1;
      end
      else
      begin
        wr_reject_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      setup_options_q <= SBCSO_SETUP_RESET;
      wr_accept_q     <= 1'b0;
      wr_reject_q     <= 1'b0;
    end
    else
    begin
      setup_options_q <= setup_options_d;
      wr_accept_q     <= wr_accept_d;
      wr_reject_q     <= wr_reject_d;
    end
  end

  // Low-power gate, debug check and safe variant
  always_comb
  begin
    lp_entry_grant_d = lp_entry_req &&
      (!cfg.lowpower_entry_code_required || lp_code_ok);
    mismatch = cfg.dbg_sel[SBCSO_B_DBG_HI] &&
               pin_variant != sel_variant(cfg.dbg_sel);
    // Set wins over a clear in the same cycle
    dbg_flag_d = mismatch || (dbg_flag_q && !dbg_flag_clear);
    if (cfg.dbg_sel[SBCSO_B_DBG_HI])
    begin
      safe_variant_d = sel_variant(cfg.dbg_sel);
    end
    else
    begin
      safe_variant_d = pin_variant;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lp_entry_grant_q <= 1'b0;
      dbg_flag_q       <= 1'b0;
      mismatch_q       <= 1'b0;
      safe_variant_q   <= SBCSO_SAFE_A;
    end
    else
    begin
      lp_entry_grant_q <= lp_entry_grant_d;
      dbg_flag_q       <= dbg_flag_d;
      mismatch_q       <= mismatch;
      safe_variant_q   <= safe_variant_d;
    end
  end

  // Interrupt pin: pulse or held level
  always_comb
  begin
    // A new mismatch raises one interrupt, not one per cycle
    irq_event = int_event || (mismatch && !mismatch_q) ||
      (cfg.int_flash && dev_mode == SBCSO_MODE_FLASH &&
       wd_half_elapsed);
    int_st_d  = int_st_q;
    int_cnt_d = int_cnt_q;
    case (int_st_q)
      SBCSO_INT_IDLE:
      begin
        if (irq_event)
        begin
          if (cfg.int_level)
          begin
            int_st_d = SBCSO_INT_HOLD;
          end
          else
          begin
            int_st_d = SBCSO_INT_PULSE;
            int_cnt_d = cfg.int_short ?
              SBCSO_CNT_W'(INT_SHORT_CYC - 1) :
              SBCSO_CNT_W'(INT_LONG_CYC - 1);
          end
        end
      end
      SBCSO_INT_PULSE:
      begin
        // Events during a pulse merge into it; the width is not stretched
        if (int_cnt_q == '0)
        begin
          int_st_d = SBCSO_INT_IDLE;
        end
        else
        begin
          int_cnt_d = int_cnt_q - SBCSO_CNT_W'(1);
        end
      end
      SBCSO_INT_HOLD:
      begin
        if (int_clear)
        begin
          int_st_d = SBCSO_INT_IDLE;
        end
      end
      default:
      begin
        int_st_d = SBCSO_INT_IDLE;
      end
    endcase
    int_n_d = (int_st_d == SBCSO_INT_IDLE);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      int_st_q  <= SBCSO_INT_IDLE;
      int_cnt_q <= '0;
      int_n_q   <= 1'b1;
    end
    else
    begin
      int_st_q  <= int_st_d;
      int_cnt_q <= int_cnt_d;
      int_n_q   <= int_n_d;
    end
  end

endmodule : sbcso_setup_options

// File: verilog/sbcso_pkg.sv
// Package for the setup options register block: offsets, fields, timing
package sbcso_pkg;

  // Register frame layout and address
  localparam logic [1:0] SBCSO_CMD_WRITE     = 2'h1;
  localparam logic [4:0] SBCSO_SETUP_OFFSET  = 5'h08;
  localparam logic [7:0] SBCSO_SETUP_RESET   = 8'h00;

  // Field positions in setup_options
  localparam int SBCSO_B_LP_CODE   = 7;
  localparam int SBCSO_B_PARITY    = 6;
  localparam int SBCSO_B_INT_LEVEL = 5;
  localparam int SBCSO_B_INT_SHORT = 4;
  localparam int SBCSO_B_INT_FLASH = 3;
  localparam int SBCSO_B_DBG_HI    = 2;

  // Timing: pulse widths in microseconds and clock rate in MHz
  localparam int SBCSO_CLK_MHZ      = 250;
  localparam int SBCSO_INT_LONG_US  = 100;
  localparam int SBCSO_INT_SHORT_US = 25;
  localparam int SBCSO_INT_LONG_CYC  = SBCSO_INT_LONG_US * SBCSO_CLK_MHZ;
  localparam int SBCSO_INT_SHORT_CYC = SBCSO_INT_SHORT_US * SBCSO_CLK_MHZ;
  localparam int SBCSO_CNT_W = 15;

  // Device operating modes as seen by this block
  typedef enum logic [1:0] {
    SBCSO_MODE_RESET,
    SBCSO_MODE_INIT,
    SBCSO_MODE_FLASH,
    SBCSO_MODE_NORMAL
  } sbcso_mode_t;

  // Safe-mode variant
  typedef enum logic [1:0] {
    SBCSO_SAFE_A,
    SBCSO_SAFE_B1,
    SBCSO_SAFE_B2,
    SBCSO_SAFE_B3
  } sbcso_variant_t;

  // One received 16-bit serial frame
  typedef struct packed {
    logic [1:0] cmd;
    logic [4:0] addr;
    logic       parity;
    logic [7:0] data;
  } sbcso_frame_t;

  // Fields of setup_options, msb first
  typedef struct packed {
    logic       lowpower_entry_code_required;
    logic       parity_en;
    logic       int_level;
    logic       int_short;
    logic       int_flash;
    logic [2:0] dbg_sel;
  } sbcso_setup_t;

endpackage : sbcso_pkg

// File: test/sbcso_setup_asserts.sv
// Checker for the setup options register block
`timescale 1ns/100ps
module sbcso_setup_asserts
  import sbcso_pkg::*;
#(
  parameter int INT_LONG_CYC  = 20,
  parameter int INT_SHORT_CYC = 5
)
(
  // Clock, reset and inputs
  input wire logic           clk,
  input wire logic           resetn,
  input wire logic           frame_valid,
  input wire sbcso_frame_t   frame,
  input wire sbcso_mode_t    dev_mode,
  input wire logic           wd_half_elapsed,
  input wire logic           int_clear,
  input wire logic           lp_entry_req,
  input wire logic           lp_code_ok,
  input wire sbcso_variant_t pin_variant,
  // Outputs
  input wire logic [7:0]     setup_options_q,
  input wire logic           wr_reject_q,
  input wire logic           lp_entry_grant_q,
  input wire logic           int_n_q,
  input wire logic           dbg_flag_q,
  input wire sbcso_variant_t safe_variant_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Low-time counter: pulse widths are too long for a repetition
  logic [15:0] low_q;
  logic [15:0] low_d;
  always_comb low_d = int_n_q ? 16'h0000 : low_q + 16'h0001;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) low_q <= 16'h0000;
    else low_q <= low_d;
  sequence wr_s;
    frame_valid && frame.cmd == SBCSO_CMD_WRITE
      && frame.addr == SBCSO_SETUP_OFFSET;
  endsequence
  logic par_bad;
  assign par_bad = frame.parity != ^{frame.cmd, frame.addr, frame.data};
  mode_lock_a:
    assert property (wr_s ##0 dev_mode != SBCSO_MODE_INIT |=> wr_reject_q
      && $stable(setup_options_q)) else $error("write outside init");
  write_take_a:
    assert property (wr_s ##0 dev_mode == SBCSO_MODE_INIT
      && !setup_options_q[6] |=> setup_options_q == $past(frame.data))
      else $error("write not stored");
  parity_drop_a:
    assert property (wr_s ##0 setup_options_q[6] && par_bad |=> wr_reject_q
      && $stable(setup_options_q)) else $error("bad parity taken");
  lp_gate_a:
    assert property (lp_entry_req |=> lp_entry_grant_q ==
      (!$past(setup_options_q[7]) || $past(lp_code_ok)))
      else $error("low-power grant wrong");
  int_hold_a:
    assert property (!int_n_q && setup_options_q[5] && !int_clear
      |=> !int_n_q) else $error("level interrupt ended");
  pulse_len_a:
    assert property ($rose(int_n_q) && !setup_options_q[5] |-> low_q ==
      (setup_options_q[4] ? INT_SHORT_CYC : INT_LONG_CYC))
      else $error("pulse width wrong");
  flash_half_a:
    assert property (int_n_q && $past(int_n_q) && setup_options_q[3]
      && dev_mode == SBCSO_MODE_FLASH && wd_half_elapsed |=> !int_n_q)
      else $error("no flash interrupt");
  dbg_flag_a:
    assert property (setup_options_q[2] && pin_variant !=
      sbcso_variant_t'(~setup_options_q[1:0]) |=> dbg_flag_q)
      else $error("debug flag not set");
  sw_safe_a:
    assert property (setup_options_q[2] && $stable(setup_options_q) |->
      safe_variant_q == sbcso_variant_t'(~setup_options_q[1:0]))
      else $error("safe variant wrong");
endmodule : sbcso_setup_asserts

bind sbcso_setup_options sbcso_setup_asserts #(
  .INT_LONG_CYC(INT_LONG_CYC), .INT_SHORT_CYC(INT_SHORT_CYC)) chk (
  .clk, .resetn, .frame_valid, .frame, .dev_mode, .wd_half_elapsed,
  .int_clear, .lp_entry_req, .lp_code_ok, .pin_variant, .setup_options_q,
  .wr_reject_q, .lp_entry_grant_q, .int_n_q, .dbg_flag_q, .safe_variant_q);

// File: test/sbcso_host_model.sv
// Host model that sends register write frames
`timescale 1ns/100ps
module sbcso_host_model
  import sbcso_pkg::*;
(
  // Clock and frame output
  input wire logic clk,
  output logic     frame_valid,
  output sbcso_frame_t frame
);
  initial frame_valid = 1'b0;
  initial frame = '0;
  // Parity is zero while unused; bad flips it to provoke a refusal
  task automatic wr(input logic [7:0] d, input logic pe, input logic bad);
    @(negedge clk);
    frame.cmd = SBCSO_CMD_WRITE;
    frame.addr = SBCSO_SETUP_OFFSET;
    frame.data = d;
    frame.parity = pe ? ^{frame.cmd, frame.addr, d} ^ bad : 1'b0;
    frame_valid = 1'b1;
    @(negedge clk);
    frame_valid = 1'b0;
    frame = ~frame;
  endtask : wr
endmodule : sbcso_host_model

// File: test/sbcso_setup_options_tb.sv
// Testbench for the setup options register block
`timescale 1ns/100ps
module sbcso_setup_options_tb
  import sbcso_pkg::*;
;
  logic clk = 1'b0, resetn = 1'b0, frame_valid, wd_half_elapsed = 1'b0;
  logic int_event = 1'b0, int_clear = 1'b0, lp_entry_req = 1'b0;
  logic lp_code_ok = 1'b0, dbg_flag_clear = 1'b0, wr_accept_q, wr_reject_q;
  logic lp_entry_grant_q, int_n_q, dbg_flag_q;
  logic [7:0] setup_options_q;
  logic [2:0] codes [4] = '{3'h7, 3'h4, 3'h5, 3'h6};
  sbcso_frame_t frame;
  sbcso_mode_t dev_mode = SBCSO_MODE_NORMAL;
  sbcso_variant_t pin_variant = SBCSO_SAFE_A, safe_variant_q;
  int fails = 0, n_checks = 0, c;
  always #2 clk = ~clk;
  sbcso_host_model host (.clk, .frame_valid, .frame);
  sbcso_setup_options #(.INT_LONG_CYC(20), .INT_SHORT_CYC(5)) dut (
    .clk, .resetn, .frame_valid, .frame, .dev_mode, .wd_half_elapsed,
    .int_event, .int_clear, .lp_entry_req, .lp_code_ok, .pin_variant,
    .dbg_flag_clear, .setup_options_q, .wr_accept_q, .wr_reject_q,
    .lp_entry_grant_q, .int_n_q, .dbg_flag_q, .safe_variant_q);
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask : pulse
  // Bounded so a stuck pin cannot hang the run
  task automatic low_len(input logic [7:0] n);
    for (c = 0; int_n_q === 1'b0 && c < 100; c++) @(negedge clk);
    chk(n, c[7:0]);
  endtask : low_len
  task automatic report_and_stop;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #20000;
    fails++;
    report_and_stop;
  end
  initial
  begin
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    chk(8'h00, setup_options_q);
    host.wr(8'h80, 1'b0, 1'b0);
    chk(8'h01, 8'(wr_reject_q));
    chk(8'h00, setup_options_q);
    dev_mode = SBCSO_MODE_INIT;
    host.wr(8'h80, 1'b0, 1'b0);
    chk(8'h80, setup_options_q);
    chk(8'h01, 8'(wr_accept_q));
    pulse(lp_entry_req);
    chk(8'h00, 8'(lp_entry_grant_q));
    lp_code_ok = 1'b1;
    pulse(lp_entry_req);
    chk(8'h01, 8'(lp_entry_grant_q));
    host.wr(8'h40, 1'b0, 1'b0);
    lp_code_ok = 1'b0;
    pulse(lp_entry_req);
    chk(8'h01, 8'(lp_entry_grant_q));
    $display("test lowpower done");
    host.wr(8'h50, 1'b1, 1'b1);
    chk(8'h40, setup_options_q);
    chk(8'h01, 8'(wr_reject_q));
    host.wr(8'h50, 1'b1, 1'b0);
    chk(8'h50, setup_options_q);
    pulse(int_event);
    low_len(8'h05);
    host.wr(8'h48, 1'b1, 1'b0);
    dev_mode = SBCSO_MODE_FLASH;
    pulse(wd_half_elapsed);
    low_len(8'h14);
    dev_mode = SBCSO_MODE_INIT;
    host.wr(8'h40, 1'b1, 1'b0);
    dev_mode = SBCSO_MODE_FLASH;
    pulse(wd_half_elapsed);
    chk(8'h01, 8'(int_n_q));
    dev_mode = SBCSO_MODE_INIT;
    host.wr(8'h60, 1'b1, 1'b0);
    pulse(int_event);
    repeat (30) @(negedge clk);
    chk(8'h00, 8'(int_n_q));
    pulse(int_clear);
    chk(8'h01, 8'(int_n_q));
    $display("test interrupt done");
    foreach (codes[i])
    begin
      host.wr({5'h08, codes[i]}, 1'b1, 1'b0);
      @(negedge clk);
      chk({6'h00, ~codes[i][1:0]}, 8'(safe_variant_q));
      chk(8'(codes[i] != 3'h7), 8'(dbg_flag_q));
    end
    pin_variant = SBCSO_SAFE_B2;
    host.wr(8'h40, 1'b1, 1'b0);
    pulse(dbg_flag_clear);
    chk(8'h00, 8'(dbg_flag_q));
    chk(8'h02, 8'(safe_variant_q));
    $display("test debug done");
    report_and_stop;
  end
endmodule : sbcso_setup_options_tb
